// File: verilog/upcc_pkg.sv
// Package for the USB PLL clock control block: register map, fields, types
package upcc_pkg;

  // Register map (byte addresses on the Avalon word bus)
  localparam logic [31:0] UPCC_CTRL_ADDR   = 32'h40004064;
  localparam logic [31:0] UPCC_STATUS_ADDR = 32'h40004068;
  localparam logic [31:0] UPCC_MASK_ADDR   = 32'h4000406C;

  // Control field positions
  localparam int UPCC_BLK_GATE_BIT = 18;
  localparam int UPCC_IN_GATE_BIT  = 17;
  localparam int UPCC_PWR_BIT      = 16;
  localparam int UPCC_BYPASS_BIT   = 15;
  localparam int UPCC_DIRECT_BIT   = 14;
  localparam int UPCC_FBSEL_BIT    = 13;
  localparam int UPCC_POST_LSB     = 11;
  localparam int UPCC_PRE_LSB      = 9;
  localparam int UPCC_FB_LSB       = 1;
  localparam int UPCC_LOCK_BIT     = 0;

  // Writable bits of the control word; bit 0 is read-only
  localparam logic [18:0] UPCC_CTRL_WMASK = 19'h7FFFE;
  localparam logic [18:0] UPCC_CTRL_RESET = 19'h00000;

  // Fixed divider in front of the PLL
  localparam logic [3:0] UPCC_FIXED_DIV = 4'hD;

  // Status / mask bit positions
  localparam int UPCC_EV_LOCK_RISE = 0;
  localparam int UPCC_EV_LOCK_FALL = 1;

  // Control fields as driven toward the analog core
  typedef struct packed {
    logic       blk_gate;
    logic       in_gate;
    logic       pwr_on;
    logic       bypass;
    logic       direct;
    logic       fb_sel;
    logic [1:0] post_div;
    logic [1:0] pre_div;
    logic [7:0] fb_div;
  } upcc_ctrl_t;

  // Decoded divider ratios for the core
  typedef struct packed {
    logic [4:0] post_ratio;
    logic [2:0] pre_ratio;
    logic [8:0] fb_ratio;
  } upcc_ratio_t;

  typedef enum logic [1:0] {
    UPCC_IDLE = 2'b00,
    UPCC_RESP = 2'b01
  } upcc_bus_state_t;

endpackage

// File: verilog/upcc_ref_div.sv
`timescale 1ns/100ps
// Fixed divide-by-13 enable generator for the PLL reference path
module upcc_ref_div
  import upcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      ref_tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } upcc_div_state_t;

  upcc_div_state_t st;
  upcc_div_state_t next_st;

  // Count 0..12, pulse once per wrap; held at zero while gated
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.cnt = 4'h0;
    end else if (st.cnt == UPCC_FIXED_DIV - 4'h1) begin
      next_st.cnt = 4'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ref_tick = st.tick;

  // Pulse spacing is exactly thirteen cycles
  a_tick_spacing: assert property (@(posedge clk) disable iff (!reset_n)
    st.tick && run |-> ##13 (st.tick || !$past(run)))
    else $error("reference tick spacing not thirteen");

endmodule

// File: verilog/upcc_top.sv
`timescale 1ns/100ps
// USB PLL clock control: Avalon-MM control register, gating, divider settings, lock status
module upcc_top
  import upcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Clock path
  input  wire logic        usb_pll_clock_in,
  input  wire logic        pll_output_clock,
  input  wire logic        pll_lock_async,
  output logic             pll_ref_enable,
  output logic             usb_block_clock_enable,
  output logic             pll_power_on,
  output logic             pll_bypass,
  output logic             pll_direct_out,
  output logic             pll_fb_select,
  output upcc_ratio_t      pll_ratio,
  output logic             pll_lock_sync,
  output logic             irq
);

  typedef struct packed {
    upcc_bus_state_t bus;
    upcc_ctrl_t      ctrl;
    logic [31:0]     rdata;
    logic [1:0]      resp;
    logic            lock_m;
    logic            lock_s;
    logic            lock_d;
    logic [1:0]      status;
    logic [1:0]      mask;
    logic            irq;
    logic            ack;
    logic            ref_en;
    logic            blk_en;
    upcc_ratio_t     ratio;
  } upcc_state_t;

  upcc_state_t st;
  upcc_state_t next_st;
  logic        ref_tick;
  logic [31:0] ctrl_word;
  logic [31:0] wr_mask;
  logic [31:0] new_ctrl;
  logic [1:0]  ev;
  logic        rd_status;

  // Divide-by-13 runs only while the PLL input gate is open
  upcc_ref_div u_ref_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (st.ctrl.in_gate),
    .ref_tick (ref_tick)
  );

  // Byte lanes expand to a bit mask for partial writes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wr_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // Readback image: bit 0 shows synchronised lock, upper bits zero
  assign ctrl_word = {13'h0000, st.ctrl, st.lock_s};
  assign new_ctrl  = (ctrl_word & ~wr_mask) | (avs_writedata & wr_mask);
  assign ev        = {st.lock_d & ~st.lock_s, st.lock_s & ~st.lock_d};
  assign rd_status = avs_read && st.bus == UPCC_IDLE && avs_address == UPCC_STATUS_ADDR;

  // Request taken in idle; writes land at the edge that sees waitrequest low
  always_comb begin
    next_st = st;
    next_st.lock_m = pll_lock_async;
    next_st.lock_s = st.lock_m;
    next_st.lock_d = st.lock_s;
    case (st.bus)
      UPCC_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.bus = UPCC_RESP;
          next_st.resp = 2'b00;
          next_st.rdata = 32'h00000000;
          if (avs_address == UPCC_CTRL_ADDR) begin
            next_st.rdata = ctrl_word;
          end else if (avs_address == UPCC_STATUS_ADDR) begin
            next_st.rdata = {30'h00000000, st.status};
          end else if (avs_address == UPCC_MASK_ADDR) begin
            next_st.rdata = {30'h00000000, st.mask};
          end else begin
            next_st.resp = 2'b11; // Unmapped: decode error
          end
        end
      end
      UPCC_RESP: begin
        next_st.bus = UPCC_IDLE;
        // Commit only while the master still holds the request
        if (avs_write && avs_address == UPCC_CTRL_ADDR) begin
          next_st.ctrl = upcc_ctrl_t'(new_ctrl[18:1]);
        end else if (avs_write && avs_address == UPCC_MASK_ADDR && avs_byteenable[0]) begin
          next_st.mask = avs_writedata[1:0];
        end
      end
      default: begin
        next_st.bus = UPCC_IDLE;
      end
    endcase
    // Sticky events; a new event wins over the clear-on-read
    next_st.status = (rd_status ? 2'b00 : st.status) | ev;
    next_st.irq = |(next_st.status & next_st.mask);
    // Registered ready: high only in the answer cycle
    next_st.ack = (next_st.bus == UPCC_RESP);
    // reference gate, applied after the fixed divider
    // reference tick only every thirteenth cycle
    next_st.ref_en = next_st.ctrl.in_gate & ref_tick;
    next_st.blk_en = next_st.ctrl.blk_gate;
    next_st.ratio.post_ratio = 5'h02 << next_st.ctrl.post_div;
    next_st.ratio.pre_ratio = {1'b0, next_st.ctrl.pre_div} + 3'h1;
    next_st.ratio.fb_ratio = {1'b0, next_st.ctrl.fb_div} + 9'h001;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.bus <= UPCC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign avs_readdata           = st.rdata;
  assign avs_response           = st.resp;
  assign avs_waitrequest        = ~st.ack;
  assign pll_ref_enable         = st.ref_en;
  assign usb_block_clock_enable = st.blk_en;
  assign pll_power_on           = st.ctrl.pwr_on;
  assign pll_bypass             = st.ctrl.bypass;
  assign pll_direct_out         = st.ctrl.direct;
  assign pll_fb_select          = st.ctrl.fb_sel;
  assign pll_ratio              = st.ratio;
  assign pll_lock_sync          = st.lock_s;
  assign irq                    = st.irq;

  // Control write reaches the gate at the same edge as the control register
  a_blk_gate: assert property (@(posedge clk) disable iff (!reset_n)
    usb_block_clock_enable == st.ctrl.blk_gate)
    else $error("block clock gate not following control");
  sequence s_bus_take;
    (avs_read || avs_write) && st.bus == UPCC_IDLE;
  endsequence
  sequence s_bus_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
    s_bus_take |-> s_bus_answer)
    else $error("bus answer not after one wait cycle");
  a_ref_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !st.ctrl.in_gate |=> !pll_ref_enable)
    else $error("reference passed while gated");
  a_pwr_field: assert property (@(posedge clk) disable iff (!reset_n)
    pll_power_on == ctrl_word[UPCC_PWR_BIT])
    else $error("power output differs from control bit");
  a_sel_bits: assert property (@(posedge clk) disable iff (!reset_n)
    {pll_bypass, pll_direct_out, pll_fb_select} == ctrl_word[15:13])
    else $error("select outputs differ from control bits");
  a_post_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    $stable(st.ctrl.post_div) |=> pll_ratio.post_ratio == (5'h02 << st.ctrl.post_div))
    else $error("post ratio wrong");
  a_pre_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    $stable(st.ctrl.pre_div) |=> pll_ratio.pre_ratio == {1'b0, st.ctrl.pre_div} + 3'h1)
    else $error("pre ratio wrong");
  a_fb_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    $stable(st.ctrl.fb_div) |=> pll_ratio.fb_ratio == {1'b0, st.ctrl.fb_div} + 9'h001)
    else $error("feedback ratio wrong");
  sequence s_ctrl_read;
    avs_read && !avs_waitrequest && st.bus == UPCC_RESP && $past(avs_address) == UPCC_CTRL_ADDR;
  endsequence
  a_lock_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_ctrl_read |-> avs_readdata[UPCC_LOCK_BIT] == $past(st.lock_s))
    else $error("lock bit readback wrong");
  a_lock_sync: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(pll_lock_async) ##1 pll_lock_async |=> pll_lock_sync)
    else $error("lock not synchronised in two cycles");

endmodule

// File: verification/upcc_pll_model.sv
`timescale 1ns/100ps
// Behavioural model of the analog PLL core that reports lock
module upcc_pll_model #(
  parameter int LOCK_TICKS = 8
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pwr_on,
  input  wire logic ref_tick,
  output logic      lock
);
  int ticks;
  // Startup counts divided ticks
  // Lock drops at once on power down, so a stale lock never survives
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ticks <= 0;
      lock  <= 1'b0;
    end else if (!pwr_on) begin
      ticks <= 0;
      lock  <= 1'b0;
    end else if (ref_tick && ticks < LOCK_TICKS) begin
      ticks <= ticks + 1;
      lock  <= (ticks + 1 == LOCK_TICKS);
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
// Self-checking testbench for the USB PLL clock control block
module tb;
  import upcc_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        lock_async;
  logic        ref_en, blk_en, pwr, byp, dir, fbs, lock_s, irq;
  upcc_ratio_t ratio;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [31:0] d, rd;
  logic [1:0]  rs;
  int          n;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  upcc_top dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .usb_pll_clock_in(1'b0), .pll_output_clock(1'b0), .pll_lock_async(lock_async),
    .pll_ref_enable(ref_en), .usb_block_clock_enable(blk_en), .pll_power_on(pwr), .pll_bypass(byp),
    .pll_direct_out(dir), .pll_fb_select(fbs), .pll_ratio(ratio), .pll_lock_sync(lock_s), .irq(irq));

  upcc_pll_model pll (.clk(clk), .reset_n(reset_n), .pwr_on(pwr), .ref_tick(ref_en), .lock(lock_async));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= we;
    avs_read       <= !we;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) check(32'h1, 32'h0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Let the edge settle before callers look at outputs
    @(negedge clk);
  endtask

  // Expected control outputs worked out from a control word
  function automatic logic [31:0] outs_exp(input logic [31:0] c);
    return {10'h0, c[18], c[16], c[15], c[14], c[13], 5'h02 << c[12:11],
            {1'b0, c[10:9]} + 3'h1, {1'b0, c[8:1]} + 9'h001};
  endfunction

  // Count reference ticks over a fixed span
  task automatic ticks(input int cyc, input int exp);
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (ref_en === 1'b1) n++;
    end
    check(n, exp);
  endtask

  // Wait a bounded time for irq to reach a level
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end

  initial begin
    void'($urandom(46));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h0);
    check({rs, 2'h0, lock_s, irq}, 6'h0);
    // Unmapped address is refused with an error response
    bus(1, 32'h40004070, 32'hFFFFFFFF, 4'hF);
    bus(0, 32'h40004070, 0, 4'hF);
    check(rd, 32'h0);
    check(rs, 32'h3);
    // Random control words; reference and block gates stay closed
    repeat (24) begin
      d = $urandom & 32'h0001FFFF;
      bus(1, UPCC_CTRL_ADDR, d, 4'hF);
      bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
      check(rd, d & 32'h0001FFFE);
      check({10'h0, blk_en, pwr, byp, dir, fbs, ratio}, outs_exp(d));
    end
    // Corner divider values, then a lane-0-only write
    bus(1, UPCC_CTRL_ADDR, 32'h1FFFE, 4'hF);
    check({10'h0, blk_en, pwr, byp, dir, fbs, ratio}, outs_exp(32'h1FFFE));
    bus(1, UPCC_CTRL_ADDR, 32'h00000, 4'h1);
    bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h1FF00);
    bus(1, UPCC_CTRL_ADDR, 32'h0, 4'hF);
    ticks(40, 0);
    bus(0, UPCC_STATUS_ADDR, 0, 4'hF);
    // Power up with events masked: lock rises, irq stays low
    bus(1, UPCC_MASK_ADDR, 32'h0, 4'hF);
    bus(1, UPCC_CTRL_ADDR, 32'h30000, 4'hF);
    // First pulse lands 14 cycles after the write, then one per 13
    ticks(130, 9);
    n = 0;
    while (lock_s !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(irq, 1'b0);
    bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h30001);
    bus(0, UPCC_STATUS_ADDR, 0, 4'hF);
    check(rd, 32'h1);
    bus(0, UPCC_STATUS_ADDR, 0, 4'hF);
    check(rd, 32'h0);
    // Block clock opened only once lock is seen
    bus(1, UPCC_CTRL_ADDR, 32'h70000, 4'hF);
    check(blk_en, 1'b1);
    bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h70001);
    // Unmask, power down with bit 0 written high: fall event raises irq
    bus(1, UPCC_MASK_ADDR, 32'h3, 4'hF);
    bus(1, UPCC_CTRL_ADDR, 32'h1, 4'hF);
    check(blk_en, 1'b0);
    wait_irq(1'b1);
    check(irq, 1'b1);
    bus(0, UPCC_CTRL_ADDR, 0, 4'hF);
    check(rd, 32'h0);
    bus(0, UPCC_STATUS_ADDR, 0, 4'hF);
    check(rd, 32'h2);
    wait_irq(1'b0);
    check(irq, 1'b0);
    final_report;
  end
endmodule
